/* File: include/cts_pkg.sv */
// Purpose: Shared constants and types for the carrier table sequencer
// Assumes: AXI4-Lite slave, 32-bit data, doubles carried as raw IEEE-754 bits
// Notes: Command, action and error codes follow enum declaration order
package cts_pkg;
  localparam int TBL_N = 32768;
  localparam int PROG_N = 16;
  localparam int STEP_CAP = 64;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INDEX = 8'h04;
  localparam logic [7:0] A_V1_LO = 8'h08;
  localparam logic [7:0] A_V1_HI = 8'h0C;
  localparam logic [7:0] A_V2_LO = 8'h10;
  localparam logic [7:0] A_V2_HI = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_R1_LO = 8'h1C;
  localparam logic [7:0] A_R1_HI = 8'h20;
  localparam logic [7:0] A_R2_LO = 8'h24;
  localparam logic [7:0] A_R2_HI = 8'h28;
  localparam logic [63:0] TONE_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] GAIN_RST = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] GAIN_MAX = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] SCALE_RST = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] PHASE_RST = 64'h0000_0000_0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    no_op, scale_wr, scale_rd, phase_wr, phase_rd, tone_wr, tone_rd, tone_clr,
    gain_wr, gain_rd, gain_clr, prog_def, prog_app, prog_rd
  } op_t;
  typedef enum logic [3:0] {
    carrier_tone_step, carrier_phase_shift, phase_load, phase_nudge_step,
    chirp_slope, chirp_go, chirp_freeze, chirp_rewind, level_step
  } act_t;
  typedef enum logic [2:0] {err_none, err_busy, err_full, err_range, err_cmd} err_t;
  typedef enum logic [1:0] {st_idle, st_run, st_sweep} state_t;
  typedef struct packed {
    act_t act;
    logic [1:0] pad;
    logic frac;
    logic ch;
    op_t op;
  } ctrl_t;
  typedef struct packed {
    logic [7:0] pad_hi;
    logic [7:0] prog;
    logic [8:0] pad_mid;
    err_t code;
    logic [1:0] pad_lo;
    logic err;
    logic busy;
  } status_t;
endpackage: cts_pkg

/* File: design/carrier_table_sequencer.sv */
// Purpose: Per-channel carrier settings, tone list, gain list and step programs
// Assumes: Commands issued through CTRL after loading INDEX, V1 and V2
// Notes: Clears sweep one entry per cycle; busy for the whole table
// Behaviour
// - Keep per-channel carrier amplitude scale, writable, readable, driven to datapath.
// - Keep per-channel carrier phase shift in cycles, writable and readable.
// - Per-channel tone list of 32K entries for sequence-selected carrier tones.
// - Tone list changes accepted only while the channel is neither armed nor running.
// - Tone writes fill consecutive entries of integral and fractional doubles; reads likewise.
// - Tone clear returns every entry of the channel's list to default.
// - Per-channel gain list of 32K scale values between zero and one.
// - Gain list changes accepted only while the channel is idle.
// - Gain writes fill consecutive entries, one double each; reads likewise.
// - Gain clear returns every entry of the channel's list to default.
// - Define allocates an empty step program and returns its index, or errors.
// - Append adds one step of action code and values; full store errors.
// - Repeated action code in one program keeps only the latest value.
// - Only the last of chirp go, freeze and rewind is kept.
// - An omitted fractional value is taken as zero.
// - While not idle only replacing appends are allowed; growth is refused.
// - Once generation stops, unrestricted step program changes are accepted again.
// - Chirp slope carries integral and fractional parts in hertz per microsecond.
`timescale 1ns/100ps
module carrier_table_sequencer (
  // Clock, reset and freeze
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Channel run state
  input wire logic [1:0] ch_armed,
  input wire logic [1:0] ch_running,
  // Carrier settings to the datapath
  output logic [1:0][63:0] carrier_scale,
  output logic [1:0][63:0] carrier_phase_shift
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction: merge

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff, rd_mux;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic rd_map;
  logic [15:0] index_ff;
  logic [63:0] v1_ff, v2_ff, rd1_ff, rd2_ff;
  logic [1:0][63:0] scale_ff, phase_ff;
  cts_pkg::ctrl_t cw_ff;
  cts_pkg::state_t state_ff;
  cts_pkg::err_t code_ff, err_nxt;
  cts_pkg::status_t st_w;
  logic err_ff;
  logic [3:0] prog_ret_ff;
  logic [14:0] sweep_ff;
  logic [1:0][4:0] prog_cnt_ff;
  logic [1:0][6:0] step_cnt_ff;
  logic [255:0] used_ff;
  logic [63:0] tone_int_mem [0:2*cts_pkg::TBL_N-1];
  logic [63:0] tone_frac_mem [0:2*cts_pkg::TBL_N-1];
  logic [63:0] gain_mem [0:2*cts_pkg::TBL_N-1];
  logic [63:0] pv1_mem [0:255];
  logic [63:0] pv2_mem [0:255];

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign carrier_scale = scale_ff;
  assign carrier_phase_shift = phase_ff;

  // Bus handshakes and write decode
  wire aw_hs = awvalid & awready_ff;
  wire w_hs = wvalid & wready_ff;
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire b_hs = bvalid_ff & bready;
  wire ar_hs = arvalid & arready_ff;
  wire r_hs = rvalid_ff & rready;
  wire busy = state_ff != cts_pkg::st_idle;
  wire sel_ctrl = aw_addr_ff == cts_pkg::A_CTRL;
  wire sel_idx = aw_addr_ff == cts_pkg::A_INDEX;
  wire sel_v1l = aw_addr_ff == cts_pkg::A_V1_LO;
  wire sel_v1h = aw_addr_ff == cts_pkg::A_V1_HI;
  wire sel_v2l = aw_addr_ff == cts_pkg::A_V2_LO;
  wire sel_v2h = aw_addr_ff == cts_pkg::A_V2_HI;
  // A command written while busy is refused with SLVERR rather than queued
  wire wr_ok = (sel_ctrl & ~busy) | sel_idx | sel_v1l | sel_v1h | sel_v2l | sel_v2h;
  wire start = wr_fire & sel_ctrl & w_strb_ff[0] & ~busy;
  wire [31:0] idx_wr = merge({16'h0000, index_ff}, w_data_ff, w_strb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= cts_pkg::RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (ce) begin
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awready_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wready_ff <= 1'b0;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? cts_pkg::RESP_OKAY : cts_pkg::RESP_SLVERR;
      end
      if (b_hs) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Read path
  always_comb begin
    st_w = '0;
    st_w.busy = busy;
    st_w.err = err_ff;
    st_w.code = code_ff;
    st_w.prog = {4'h0, prog_ret_ff};
  end

  always_comb begin
    rd_map = 1'b1;
    case (araddr)
      cts_pkg::A_CTRL: rd_mux = {20'h00000, cw_ff};
      cts_pkg::A_INDEX: rd_mux = {16'h0000, index_ff};
      cts_pkg::A_V1_LO: rd_mux = v1_ff[31:0];
      cts_pkg::A_V1_HI: rd_mux = v1_ff[63:32];
      cts_pkg::A_V2_LO: rd_mux = v2_ff[31:0];
      cts_pkg::A_V2_HI: rd_mux = v2_ff[63:32];
      cts_pkg::A_STATUS: rd_mux = st_w;
      cts_pkg::A_R1_LO: rd_mux = rd1_ff[31:0];
      cts_pkg::A_R1_HI: rd_mux = rd1_ff[63:32];
      cts_pkg::A_R2_LO: rd_mux = rd2_ff[31:0];
      cts_pkg::A_R2_HI: rd_mux = rd2_ff[63:32];
      default: begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= cts_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_map ? cts_pkg::RESP_OKAY : cts_pkg::RESP_SLVERR;
      end
      if (r_hs) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Command decode
  wire run = state_ff == cts_pkg::st_run;
  wire sweeping = state_ff == cts_pkg::st_sweep;
  wire ch = cw_ff.ch;
  wire ch_idle = ~ch_armed[ch] & ~ch_running[ch];
  wire idx_bad = index_ff[15];
  wire [15:0] maddr = {ch, index_ff[14:0]};
  wire [63:0] val2 = cw_ff.frac ? v2_ff : 64'h0000_0000_0000_0000;
  wire gain_ok = ~v1_ff[63] & (v1_ff <= cts_pkg::GAIN_MAX);
  wire prog_bad = index_ff >= {11'h000, prog_cnt_ff[ch]};
  wire act_bad = cw_ff.act > cts_pkg::level_step;
  wire is_chirp = cw_ff.act >= cts_pkg::chirp_go && cw_ff.act <= cts_pkg::chirp_rewind;
  // The three chirp controls share one slot so only the last survives
  wire [2:0] slot = is_chirp ? 3'h5 : (cw_ff.act == cts_pkg::level_step) ? 3'h6 :
                    cw_ff.act[2:0];
  wire [7:0] sa = {ch, index_ff[3:0], slot};
  wire slot_new = ~used_ff[sa];
  wire [3:0] cnt_now = prog_cnt_ff[ch][3:0];
  wire [6:0] steps_now = step_cnt_ff[ch];

  always_comb begin
    err_nxt = cts_pkg::err_none;
    case (cw_ff.op)
      cts_pkg::scale_wr, cts_pkg::scale_rd, cts_pkg::phase_wr, cts_pkg::phase_rd: begin
        err_nxt = cts_pkg::err_none;
      end
      cts_pkg::tone_wr, cts_pkg::gain_wr: begin
        if (!ch_idle) err_nxt = cts_pkg::err_busy;
        else if (idx_bad) err_nxt = cts_pkg::err_range;
        else if (cw_ff.op == cts_pkg::gain_wr && !gain_ok) err_nxt = cts_pkg::err_range;
      end
      cts_pkg::tone_rd, cts_pkg::gain_rd: begin
        if (idx_bad) err_nxt = cts_pkg::err_range;
      end
      cts_pkg::tone_clr, cts_pkg::gain_clr: begin
        if (!ch_idle) err_nxt = cts_pkg::err_busy;
      end
      cts_pkg::prog_def: begin
        if (!ch_idle) err_nxt = cts_pkg::err_busy;
        else if (prog_cnt_ff[ch] == 5'(cts_pkg::PROG_N)) err_nxt = cts_pkg::err_full;
      end
      cts_pkg::prog_app: begin
        if (prog_bad || act_bad) err_nxt = cts_pkg::err_range;
        else if (slot_new && !ch_idle) err_nxt = cts_pkg::err_busy;
        else if (slot_new && step_cnt_ff[ch] == 7'(cts_pkg::STEP_CAP)) begin
          err_nxt = cts_pkg::err_full;
        end
      end
      cts_pkg::prog_rd: begin
        if (prog_bad || act_bad) err_nxt = cts_pkg::err_range;
      end
      default: err_nxt = cts_pkg::err_cmd;
    endcase
  end

  wire ok = err_nxt == cts_pkg::err_none;
  wire go = run & ok;
  wire do_tone_wr = go & (cw_ff.op == cts_pkg::tone_wr);
  wire do_gain_wr = go & (cw_ff.op == cts_pkg::gain_wr);
  wire do_def = go & (cw_ff.op == cts_pkg::prog_def);
  wire do_app = go & (cw_ff.op == cts_pkg::prog_app);
  wire is_clr = cw_ff.op == cts_pkg::tone_clr || cw_ff.op == cts_pkg::gain_clr;
  wire step_idx = go & (cw_ff.op == cts_pkg::tone_wr || cw_ff.op == cts_pkg::tone_rd ||
                        cw_ff.op == cts_pkg::gain_wr || cw_ff.op == cts_pkg::gain_rd);

  // Host-loaded index and values; command stepping takes priority over a bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_ff <= 16'h0000;
      v1_ff <= 64'h0000_0000_0000_0000;
      v2_ff <= 64'h0000_0000_0000_0000;
    end else if (ce) begin
      if (step_idx) index_ff <= index_ff + 16'h0001;
      else if (wr_fire && sel_idx) index_ff <= idx_wr[15:0];
      if (wr_fire && sel_v1l) v1_ff[31:0] <= merge(v1_ff[31:0], w_data_ff, w_strb_ff);
      if (wr_fire && sel_v1h) v1_ff[63:32] <= merge(v1_ff[63:32], w_data_ff, w_strb_ff);
      if (wr_fire && sel_v2l) v2_ff[31:0] <= merge(v2_ff[31:0], w_data_ff, w_strb_ff);
      if (wr_fire && sel_v2h) v2_ff[63:32] <= merge(v2_ff[63:32], w_data_ff, w_strb_ff);
    end
  end

  // Sequencer and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= cts_pkg::st_idle;
      cw_ff <= '0;
      err_ff <= 1'b0;
      code_ff <= cts_pkg::err_none;
      prog_ret_ff <= 4'h0;
      sweep_ff <= 15'h0000;
    end else if (ce) begin
      case (state_ff)
        cts_pkg::st_idle: begin
          if (start) begin
            cw_ff <= cts_pkg::ctrl_t'(w_data_ff[11:0]);
            err_ff <= 1'b0;
            state_ff <= cts_pkg::st_run;
          end
        end
        cts_pkg::st_run: begin
          err_ff <= ~ok;
          code_ff <= err_nxt;
          sweep_ff <= 15'h0000;
          state_ff <= (ok && is_clr) ? cts_pkg::st_sweep : cts_pkg::st_idle;
          if (do_def) prog_ret_ff <= cnt_now;
        end
        cts_pkg::st_sweep: begin
          sweep_ff <= sweep_ff + 15'h0001;
          if (&sweep_ff) state_ff <= cts_pkg::st_idle;
        end
        default: state_ff <= cts_pkg::st_idle;
      endcase
    end
  end

  // Table stores; a clear rewrites one entry per cycle instead of a wide reset
  wire clr_tone = sweeping & (cw_ff.op == cts_pkg::tone_clr);
  wire clr_gain = sweeping & (cw_ff.op == cts_pkg::gain_clr);
  wire [15:0] wa = sweeping ? {ch, sweep_ff} : maddr;
  wire [63:0] t1_wd = sweeping ? cts_pkg::TONE_RST : v1_ff;
  wire [63:0] t2_wd = sweeping ? cts_pkg::TONE_RST : val2;
  wire [63:0] g_wd = sweeping ? cts_pkg::GAIN_RST : v1_ff;

  always_ff @(posedge aclk) begin
    if (ce) begin
      if (do_tone_wr || clr_tone) begin
        tone_int_mem[wa] <= t1_wd;
        tone_frac_mem[wa] <= t2_wd;
      end
      if (do_gain_wr || clr_gain) gain_mem[wa] <= g_wd;
      if (do_app) begin
        pv1_mem[sa] <= is_chirp ? {60'h0, cw_ff.act} : v1_ff;
        pv2_mem[sa] <= val2;
      end
    end
  end

  // Step program bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_cnt_ff <= '0;
      step_cnt_ff <= '0;
      used_ff <= '0;
    end else if (ce) begin
      if (do_def) prog_cnt_ff[ch] <= prog_cnt_ff[ch] + 5'h01;
      if (do_app && slot_new) begin
        used_ff[sa] <= 1'b1;
        step_cnt_ff[ch] <= step_cnt_ff[ch] + 7'h01;
      end
    end
  end

  // Carrier settings and read results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scale_ff <= {2{cts_pkg::SCALE_RST}};
      phase_ff <= {2{cts_pkg::PHASE_RST}};
      rd1_ff <= 64'h0000_0000_0000_0000;
      rd2_ff <= 64'h0000_0000_0000_0000;
    end else if (ce && go) begin
      case (cw_ff.op)
        cts_pkg::scale_wr: scale_ff[ch] <= v1_ff;
        cts_pkg::phase_wr: phase_ff[ch] <= v1_ff;
        cts_pkg::scale_rd: rd1_ff <= scale_ff[ch];
        cts_pkg::phase_rd: rd1_ff <= phase_ff[ch];
        cts_pkg::tone_rd: begin
          rd1_ff <= tone_int_mem[maddr];
          rd2_ff <= tone_frac_mem[maddr];
        end
        cts_pkg::gain_rd: rd1_ff <= gain_mem[maddr];
        cts_pkg::prog_rd: begin
          rd1_ff <= used_ff[sa] ? pv1_mem[sa] : 64'h0000_0000_0000_0000;
          rd2_ff <= used_ff[sa] ? pv2_mem[sa] : 64'h0000_0000_0000_0000;
        end
        default: rd1_ff <= rd1_ff;
      endcase
    end
  end

  // Checks
  property p_tone_lock;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::tone_wr && !ch_idle |=>
      err_ff && code_ff == cts_pkg::err_busy;
  endproperty
  a_tone_lock: assert property (p_tone_lock) else $error("tone write not refused");

  property p_gain_lock;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::gain_clr && !ch_idle |=> !sweeping && err_ff;
  endproperty
  a_gain_lock: assert property (p_gain_lock) else $error("gain clear not refused");

  property p_gain_range;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::gain_wr && ch_idle && !idx_bad && !gain_ok |=>
      code_ff == cts_pkg::err_range && $stable(index_ff);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("bad gain accepted");

  property p_idx_step;
    @(posedge aclk) disable iff (!aresetn)
    ce && do_tone_wr |=> index_ff == $past(index_ff) + 16'h0001;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not advance");

  property p_clr_sweep;
    @(posedge aclk) disable iff (!aresetn)
    ce && go && cw_ff.op == cts_pkg::tone_clr |=> sweeping [*8];
  endproperty
  a_clr_sweep: assert property (p_clr_sweep) else $error("clear sweep missing");

  property p_def_full;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::prog_def && ch_idle &&
      prog_cnt_ff[ch] == 5'(cts_pkg::PROG_N) |=> code_ff == cts_pkg::err_full;
  endproperty
  a_def_full: assert property (p_def_full) else $error("full store not reported");

  property p_def_idx;
    @(posedge aclk) disable iff (!aresetn)
    ce && do_def |=> prog_ret_ff == $past(cnt_now) && !err_ff;
  endproperty
  a_def_idx: assert property (p_def_idx) else $error("wrong program index");

  property p_grow_lock;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::prog_app && !prog_bad && !act_bad && slot_new &&
      !ch_idle |=> err_ff && $stable(steps_now);
  endproperty
  a_grow_lock: assert property (p_grow_lock) else $error("growth while busy");

  property p_scale_set;
    @(posedge aclk) disable iff (!aresetn)
    ce && run && cw_ff.op == cts_pkg::scale_wr |=> scale_ff[ch] == $past(v1_ff);
  endproperty
  a_scale_set: assert property (p_scale_set) else $error("scale not stored");

  property p_frac_zero;
    @(posedge aclk) disable iff (!aresetn)
    ce && do_app && !cw_ff.frac |=> pv2_mem[$past(sa)] == 64'h0000_0000_0000_0000;
  endproperty
  a_frac_zero: assert property (p_frac_zero) else $error("fraction not zero");

  c_sweep: cover property (@(posedge aclk) disable iff (!aresetn) run ##1 sweeping);
  c_define: cover property (@(posedge aclk) disable iff (!aresetn) ce && do_def);
  c_refuse: cover property (@(posedge aclk) disable iff (!aresetn)
    run && err_nxt == cts_pkg::err_busy);
endmodule: carrier_table_sequencer

/* File: verification/run_state_model.sv */
// Purpose: Channel run state seen by the block
// Assumes: One go request per channel from the bench
// Notes: Arms one edge before it runs, so both busy states are seen
`timescale 1ns/100ps
module run_state_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and state
  input wire logic [1:0] go,
  output logic [1:0] ch_armed,
  output logic [1:0] ch_running
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_armed <= 2'h0;
      ch_running <= 2'h0;
    end else begin
      ch_armed <= go;
      ch_running <= go & ch_armed;
    end
  end
endmodule: run_state_model

/* File: verification/test_carrier_table_sequencer.sv */
// Purpose: Self-checking bench for the carrier table sequencer
// Assumes: AXI4-Lite master tasks, ce held high
// Notes: Only channel 0 tables are cleared, each clear costs 32K cycles
`timescale 1ns/100ps
module test_carrier_table_sequencer;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, go, ch_armed, ch_running;
  logic [1:0][63:0] carrier_scale, carrier_phase_shift;
  logic [63:0] v;
  cts_pkg::status_t st;
  int bad_count, cmp_count, i;
  localparam logic [63:0] k_half = 64'h3FE0_0000_0000_0000;
  localparam logic [63:0] k_two = 64'h4000_0000_0000_0000;
  localparam logic [63:0] k_ghz = 64'h41CD_CD65_0000_0000;
  localparam logic [63:0] k_big = 64'h3FF8_0000_0000_0000;
  localparam logic [63:0] k_p9 = 64'h3FEC_CCCC_CCCC_CCCD;

  carrier_table_sequencer dut_u (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ch_armed, .ch_running, .carrier_scale,
    .carrier_phase_shift);
  run_state_model part_u (.aclk, .aresetn, .go, .ch_armed, .ch_running);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask: final_report

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask: chk

  // Address and data are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      bad_count++;
      $display("ERROR write response expected bvalid seen timeout");
    end
    bready <= 1'b0;
    resp = bresp;
  endtask: wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      bad_count++;
      $display("ERROR read response expected rvalid seen timeout");
    end
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask: rd

  // Polls busy, since clears run far longer than other commands
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    for (n = 0; n < 20000; n++) begin
      rd(cts_pkg::A_STATUS, s);
      if (!s[0]) break;
    end
    if (n == 20000) begin
      bad_count++;
      $display("ERROR busy expected 0 seen 1");
    end
    st = s;
  endtask: wait_idle

  task automatic cmd(input cts_pkg::op_t op, input logic [15:0] ix = 16'h0,
    input logic [63:0] a = 64'h0, input logic [63:0] b = 64'h0,
    input cts_pkg::act_t ac = cts_pkg::carrier_tone_step, input logic fr = 1'b0,
    input logic c = 1'b0);
    wr(cts_pkg::A_INDEX, {16'h0, ix});
    wr(cts_pkg::A_V1_LO, a[31:0]);
    wr(cts_pkg::A_V1_HI, a[63:32]);
    wr(cts_pkg::A_V2_LO, b[31:0]);
    wr(cts_pkg::A_V2_HI, b[63:32]);
    wr(cts_pkg::A_CTRL, 32'(cts_pkg::ctrl_t'{ac, 2'h0, fr, c, op}));
    wait_idle();
  endtask: cmd

  task automatic res(input logic [7:0] a, input logic [63:0] e);
    rd(a, v[31:0]);
    rd(a + 8'h04, v[63:32]);
    chk("result", e, v);
    chk("rresp", 64'(cts_pkg::RESP_OKAY), 64'(resp));
  endtask: res

  task automatic ec(input cts_pkg::err_t e);
    chk("status code", 64'(e), 64'(st.code));
    chk("status err", 64'(e != cts_pkg::err_none), 64'(st.err));
  endtask: ec

  initial begin
    repeat (100000) @(posedge aclk);
    $display("ERROR watchdog expected finish seen timeout");
    bad_count++;
    final_report();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, bad_count, cmp_count} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("scale", cts_pkg::SCALE_RST, carrier_scale[0]);
    chk("phase", cts_pkg::PHASE_RST, carrier_phase_shift[0]);
    cmd(cts_pkg::scale_wr, 0, k_p9);
    chk("scale", k_p9, carrier_scale[0]);
    cmd(cts_pkg::phase_wr, 0, k_half);
    chk("phase", k_half, carrier_phase_shift[0]);
    cmd(cts_pkg::phase_rd);
    res(cts_pkg::A_R1_LO, k_half);
    cmd(cts_pkg::scale_wr, 0, k_two, 0, cts_pkg::carrier_tone_step, 1'b0, 1'b1);
    chk("scale1", k_two, carrier_scale[1]);
    chk("scale0", k_p9, carrier_scale[0]);
    chk("phase1", cts_pkg::PHASE_RST, carrier_phase_shift[1]);
    cmd(cts_pkg::scale_rd);
    res(cts_pkg::A_R1_LO, k_p9);
    wr(cts_pkg::A_CTRL, 32'(cts_pkg::tone_clr));
    chk("ctrl resp", 64'(cts_pkg::RESP_OKAY), 64'(resp));
    // A second command while the sweep runs must be refused
    wr(cts_pkg::A_CTRL, 32'(cts_pkg::gain_clr));
    chk("busy ctrl", 64'(cts_pkg::RESP_SLVERR), 64'(resp));
    wait_idle();
    cmd(cts_pkg::tone_wr, 16'd5, k_ghz, k_half, cts_pkg::carrier_tone_step, 1'b1);
    rd(cts_pkg::A_INDEX, v[31:0]);
    chk("index", 64'h6, {48'h0, v[15:0]});
    wstrb <= 4'h2;
    wr(cts_pkg::A_INDEX, 32'h0000_AB00);
    wstrb <= 4'hF;
    rd(cts_pkg::A_INDEX, v[31:0]);
    chk("index merge", 64'hAB06, {48'h0, v[15:0]});
    cmd(cts_pkg::tone_wr, 16'd6, k_two, k_half);
    cmd(cts_pkg::tone_rd, 16'd5);
    res(cts_pkg::A_R1_LO, k_ghz);
    res(cts_pkg::A_R2_LO, k_half);
    cmd(cts_pkg::tone_rd, 16'd6);
    res(cts_pkg::A_R2_LO, 64'h0);
    cmd(cts_pkg::tone_rd, 16'd7);
    res(cts_pkg::A_R1_LO, cts_pkg::TONE_RST);
    cmd(cts_pkg::tone_wr, 16'h8000, k_two);
    ec(cts_pkg::err_range);
    cmd(cts_pkg::gain_clr);
    cmd(cts_pkg::gain_wr, 16'd3, cts_pkg::GAIN_MAX);
    cmd(cts_pkg::gain_wr, 16'd4, k_big);
    ec(cts_pkg::err_range);
    cmd(cts_pkg::gain_rd, 16'd3);
    res(cts_pkg::A_R1_LO, cts_pkg::GAIN_MAX);
    cmd(cts_pkg::gain_rd, 16'd4);
    res(cts_pkg::A_R1_LO, cts_pkg::GAIN_RST);
    cmd(cts_pkg::prog_def);
    chk("program", 64'h0, 64'(st.prog));
    cmd(cts_pkg::prog_app, 0, k_half);
    cmd(cts_pkg::prog_app, 0, k_two);
    cmd(cts_pkg::prog_rd);
    res(cts_pkg::A_R1_LO, k_two);
    cmd(cts_pkg::prog_app, 0, 0, 0, cts_pkg::chirp_go);
    cmd(cts_pkg::prog_app, 0, 0, 0, cts_pkg::chirp_freeze);
    cmd(cts_pkg::prog_rd, 0, 0, 0, cts_pkg::chirp_go);
    res(cts_pkg::A_R1_LO, 64'(cts_pkg::chirp_freeze));
    cmd(cts_pkg::prog_app, 0, 0, 0, cts_pkg::act_t'(4'h9));
    ec(cts_pkg::err_range);
    cmd(cts_pkg::prog_app, 16'd1, k_two);
    ec(cts_pkg::err_range);
    cmd(cts_pkg::no_op);
    ec(cts_pkg::err_cmd);
    go <= 2'b01;
    repeat (3) @(posedge aclk);
    cmd(cts_pkg::tone_wr, 16'd9, k_two);
    ec(cts_pkg::err_busy);
    cmd(cts_pkg::gain_wr, 16'd9, k_half);
    ec(cts_pkg::err_busy);
    cmd(cts_pkg::gain_clr);
    ec(cts_pkg::err_busy);
    cmd(cts_pkg::tone_wr, 16'd9, k_two, 0, cts_pkg::carrier_tone_step, 1'b0, 1'b1);
    ec(cts_pkg::err_none);
    cmd(cts_pkg::prog_app, 0, 0, 0, cts_pkg::chirp_rewind);
    ec(cts_pkg::err_none);
    cmd(cts_pkg::prog_def);
    ec(cts_pkg::err_busy);
    cmd(cts_pkg::prog_app, 0, k_two, k_half, cts_pkg::chirp_slope);
    ec(cts_pkg::err_busy);
    // Program 0 already holds a carrier_tone_step step, so replacing here is legal
    cmd(cts_pkg::prog_app, 0, k_ghz);
    ec(cts_pkg::err_none);
    go <= 2'b00;
    repeat (3) @(posedge aclk);
    cmd(cts_pkg::prog_app, 0, k_two, k_half, cts_pkg::chirp_slope, 1'b1);
    ec(cts_pkg::err_none);
    cmd(cts_pkg::prog_rd, 0, 0, 0, cts_pkg::chirp_slope);
    res(cts_pkg::A_R2_LO, k_half);
    cmd(cts_pkg::prog_rd, 0, 0, 0, cts_pkg::chirp_go);
    res(cts_pkg::A_R1_LO, 64'(cts_pkg::chirp_rewind));
    cmd(cts_pkg::prog_rd);
    res(cts_pkg::A_R1_LO, k_ghz);
    cmd(cts_pkg::tone_rd, 16'd9, 0, 0, cts_pkg::carrier_tone_step, 1'b0, 1'b1);
    res(cts_pkg::A_R1_LO, k_two);
    for (i = 1; i < cts_pkg::PROG_N; i++) begin
      cmd(cts_pkg::prog_def);
      chk("program", 64'(i), 64'(st.prog));
    end
    cmd(cts_pkg::prog_def);
    ec(cts_pkg::err_full);
    rd(8'h3C, v[31:0]);
    chk("unmapped", 64'(cts_pkg::RESP_SLVERR), 64'(resp));
    wr(cts_pkg::A_STATUS, 32'h0);
    chk("read only", 64'(cts_pkg::RESP_SLVERR), 64'(resp));
    final_report();
  end
endmodule: test_carrier_table_sequencer
